// >>> include/spld_pkg.sv
package spld_pkg;

    // ----------------------------------------------------------------
    // structure
    // ----------------------------------------------------------------
    localparam int unsigned SPLD_STAGES = 64;
    localparam int unsigned SPLD_FIFO_DEPTH = 8;
    localparam int unsigned SPLD_CNT_W = 4;
    localparam int unsigned SPLD_AW = 8;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SPLD_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPLD_STATUS_OFS = 8'h04;
    localparam logic [7:0] SPLD_SNAP_LO_OFS = 8'h08;
    localparam logic [7:0] SPLD_SNAP_HI_OFS = 8'h0C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned SPLD_CTRL_CAP = 0;
    localparam int unsigned SPLD_ST_DIR = 0;
    localparam int unsigned SPLD_ST_CASC = 1;
    localparam int unsigned SPLD_ST_OVR = 2;
    localparam int unsigned SPLD_ST_EMPTY = 3;
    localparam int unsigned SPLD_ST_FULL = 4;
    localparam int unsigned SPLD_ST_LVL = 8;
    localparam logic SPLD_CAP_RST = 1'b1;
    localparam logic [63:0] SPLD_SHIFT_RST = 64'h0;

    // ----------------------------------------------------------------
    // synchroniser lanes
    // ----------------------------------------------------------------
    localparam int unsigned SPLD_SYNC_W = 7;
    localparam int unsigned SPLD_IN_CLK = 0;
    localparam int unsigned SPLD_IN_LATCH = 1;
    localparam int unsigned SPLD_IN_BLANK = 2;
    localparam int unsigned SPLD_IN_POLAR = 3;
    localparam int unsigned SPLD_IN_DIR = 4;
    localparam int unsigned SPLD_IN_A = 5;
    localparam int unsigned SPLD_IN_B = 6;

    // ----------------------------------------------------------------
    // timing (advisory settle time for the controller)
    // ----------------------------------------------------------------
    localparam int unsigned SPLD_CLK_PERIOD_NS = 5;
    localparam int unsigned SPLD_LATCH_SETTLE_NS = 25;
    localparam int unsigned SPLD_LATCH_SETTLE_CYC =
        (SPLD_LATCH_SETTLE_NS + SPLD_CLK_PERIOD_NS - 1) / SPLD_CLK_PERIOD_NS;

endpackage

// >>> rtl/spld_fifo.sv
`timescale 1ns/1ps
module spld_fifo #(
    parameter int unsigned WIDTH = 64,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned CW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
        logic [PW-1:0] wr_reg;
        logic [PW-1:0] rd_reg;
        logic [CW-1:0] cnt_reg;
    } spld_fifo_st_t;

    spld_fifo_st_t st_reg, st_next;
    logic push, pop;

    assign in_ready = (st_reg.cnt_reg != CW'(DEPTH));
    assign out_valid = (st_reg.cnt_reg != '0);
    assign out_data = st_reg.mem_reg[st_reg.rd_reg];
    assign count = st_reg.cnt_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem_reg[st_reg.wr_reg] = in_data;
            st_next.wr_reg = PW'(st_reg.wr_reg + 1'b1);
        end
        if (pop) begin
            st_next.rd_reg = PW'(st_reg.rd_reg + 1'b1);
        end
        if (push && !pop) begin
            st_next.cnt_reg = CW'(st_reg.cnt_reg + 1'b1);
        end else if (pop && !push) begin
            st_next.cnt_reg = CW'(st_reg.cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.cnt_reg <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule // spld_fifo

// >>> rtl/spld_out_ctrl.sv
`timescale 1ns/1ps
module spld_out_ctrl
    import spld_pkg::*;
(
    input wire logic [SPLD_STAGES-1:0] latch_q,
    input wire logic blank_ctl,
    input wire logic polar_sel,
    output logic [SPLD_STAGES-1:0] hv_d
);
    // ----------------------------------------------------------------
    // per-channel polarity and blanking
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SPLD_STAGES; i++) begin : g_ch
            // blank low forces all channels to the inverse of polarity
            assign hv_d[i] = blank_ctl ? (polar_sel ? latch_q[i] : ~latch_q[i])
                                       : ~polar_sel;
        end
    endgenerate
endmodule // spld_out_ctrl

// >>> rtl/spld_driver.sv
`timescale 1ns/1ps
module spld_driver
    import spld_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SPLD_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shift_clock_in,
    input wire logic latch_transparent_enable,
    input wire logic output_blanking_control,
    input wire logic output_polarity_select,
    input wire logic shift_direction,
    input wire logic end_a_serial_io_in,
    output logic end_a_serial_io_out,
    output logic end_a_serial_io_oe_n,
    input wire logic end_b_serial_io_in,
    output logic end_b_serial_io_out,
    output logic end_b_serial_io_oe_n,
    output logic [SPLD_STAGES-1:0] high_voltage_parallel_output
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SPLD_SYNC_W-1:0] sync1_reg;
        logic [SPLD_SYNC_W-1:0] sync2_reg;
        logic clk_d_reg;
        logic latch_d_reg;
        logic [SPLD_STAGES-1:0] shift_reg;
        logic [SPLD_STAGES-1:0] latch_reg;
        logic [SPLD_STAGES-1:0] hv_reg;
        logic casc_reg;
        logic a_oe_n_reg;
        logic b_oe_n_reg;
        logic cap_en_reg;
        logic ovr_reg;
        logic pend_valid_reg;
        logic [SPLD_STAGES-1:0] pend_reg;
        logic [31:0] prdata_reg;
    } spld_state_t;

    spld_state_t st_reg, st_next;

    // ----------------------------------------------------------------
    // address decode, one-hot {snap_hi, snap_lo, status, ctrl}
    // ----------------------------------------------------------------
    function automatic logic [3:0] spld_decode(input logic [SPLD_AW-1:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        unique case (a)
            SPLD_CTRL_OFS: sel = 4'h1;
            SPLD_STATUS_OFS: sel = 4'h2;
            SPLD_SNAP_LO_OFS: sel = 4'h4;
            SPLD_SNAP_HI_OFS: sel = 4'h8;
            default: sel = 4'h0;
        endcase
        return sel;
    endfunction

    // ----------------------------------------------------------------
    // synchronised pins and events
    // ----------------------------------------------------------------
    logic s_clk, s_latch_en, s_blank, s_polar, s_dir, s_a, s_b;
    logic clk_rise, latch_fall;

    assign s_clk = st_reg.sync2_reg[SPLD_IN_CLK];
    assign s_latch_en = st_reg.sync2_reg[SPLD_IN_LATCH];
    assign s_blank = st_reg.sync2_reg[SPLD_IN_BLANK];
    assign s_polar = st_reg.sync2_reg[SPLD_IN_POLAR];
    assign s_dir = st_reg.sync2_reg[SPLD_IN_DIR];
    assign s_a = st_reg.sync2_reg[SPLD_IN_A];
    assign s_b = st_reg.sync2_reg[SPLD_IN_B];
    // edges are taken from the second stage only, never from the first
    assign clk_rise = s_clk && !st_reg.clk_d_reg;
    assign latch_fall = st_reg.latch_d_reg && !s_latch_en;

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    logic setup_ph, wr_acc, rd_acc;
    logic [3:0] sel;

    assign sel = spld_decode(paddr);
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && (spld_decode(paddr) == 4'h0);
    assign prdata = st_reg.prdata_reg;

    // ----------------------------------------------------------------
    // frame snapshot fifo
    // ----------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SPLD_STAGES-1:0] fifo_out_data;
    logic [SPLD_CNT_W-1:0] fifo_count;

    // reading the high word pops the frame, so read low before high
    assign fifo_out_ready = rd_acc && sel[3];

    spld_fifo #(
        .WIDTH(SPLD_STAGES),
        .DEPTH(SPLD_FIFO_DEPTH),
        .CW(SPLD_CNT_W)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(st_reg.pend_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data(st_reg.pend_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ----------------------------------------------------------------
    // output control
    // ----------------------------------------------------------------
    logic [SPLD_STAGES-1:0] hv_d;

    spld_out_ctrl u_out (
        .latch_q(st_reg.latch_reg),
        .blank_ctl(s_blank),
        .polar_sel(s_polar),
        .hv_d(hv_d)
    );

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    logic [31:0] status_w;

    always_comb begin
        status_w = 32'h0;
        status_w[SPLD_ST_DIR] = s_dir;
        status_w[SPLD_ST_CASC] = st_reg.casc_reg;
        status_w[SPLD_ST_OVR] = st_reg.ovr_reg;
        status_w[SPLD_ST_EMPTY] = !fifo_out_valid;
        status_w[SPLD_ST_FULL] = !fifo_in_ready;
        status_w[SPLD_ST_LVL +: SPLD_CNT_W] = fifo_count;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.sync1_reg = {end_b_serial_io_in, end_a_serial_io_in,
            shift_direction, output_polarity_select, output_blanking_control,
            latch_transparent_enable, shift_clock_in};
        st_next.sync2_reg = st_reg.sync1_reg;
        st_next.clk_d_reg = s_clk;
        st_next.latch_d_reg = s_latch_en;

        // shifting looks at clock, direction and data only
        if (clk_rise) begin
            if (s_dir) begin
                st_next.shift_reg = {st_reg.shift_reg[SPLD_STAGES-2:0], s_a};
            end else begin
                st_next.shift_reg = {s_b, st_reg.shift_reg[SPLD_STAGES-1:1]};
            end
        end

        // latches modelled as a clocked follower, one cycle behind
        if (s_latch_en) begin
            st_next.latch_reg = st_reg.shift_reg;
        end

        st_next.hv_reg = hv_d;

        // cascade is the stage furthest from the data entry end
        st_next.casc_reg = s_dir ? st_reg.shift_reg[SPLD_STAGES-1]
                                 : st_reg.shift_reg[0];
        st_next.a_oe_n_reg = s_dir;
        st_next.b_oe_n_reg = !s_dir;

        // register writes
        if (wr_acc && sel[0]) begin
            st_next.cap_en_reg = pwdata[SPLD_CTRL_CAP];
        end
        if (wr_acc && sel[1] && pwdata[SPLD_ST_OVR]) begin
            st_next.ovr_reg = 1'b0;
        end

        // snapshot on latch close; a stalled fifo holds the pending frame
        if (st_reg.pend_valid_reg && fifo_in_ready) begin
            st_next.pend_valid_reg = 1'b0;
        end
        if (latch_fall && st_reg.cap_en_reg) begin
            if (st_reg.pend_valid_reg && !fifo_in_ready) begin
                // set wins over a same-cycle software clear
                st_next.ovr_reg = 1'b1;
            end else begin
                st_next.pend_valid_reg = 1'b1;
                st_next.pend_reg = st_reg.latch_reg;
            end
        end

        // read data is prepared in the setup cycle
        if (setup_ph && !pwrite) begin
            st_next.prdata_reg = 32'h0;
            if (sel[0]) begin
                st_next.prdata_reg[SPLD_CTRL_CAP] = st_reg.cap_en_reg;
            end
            if (sel[1]) begin
                st_next.prdata_reg = status_w;
            end
            if (sel[2] && fifo_out_valid) begin
                st_next.prdata_reg = fifo_out_data[31:0];
            end
            if (sel[3] && fifo_out_valid) begin
                st_next.prdata_reg = fifo_out_data[63:32];
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.shift_reg <= SPLD_SHIFT_RST;
            st_reg.a_oe_n_reg <= 1'b1;
            st_reg.b_oe_n_reg <= 1'b1;
            st_reg.cap_en_reg <= SPLD_CAP_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // both ends carry the cascade; the enables decide which one drives
    assign end_a_serial_io_out = st_reg.casc_reg;
    assign end_b_serial_io_out = st_reg.casc_reg;
    assign end_a_serial_io_oe_n = st_reg.a_oe_n_reg;
    assign end_b_serial_io_oe_n = st_reg.b_oe_n_reg;
    assign high_voltage_parallel_output = st_reg.hv_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_shift_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_rise |=> $stable(st_reg.shift_reg))
        else $error("shift register moved without a clock edge");

    a_shift_up: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_rise && s_dir) |=> (st_reg.shift_reg ==
            {$past(st_reg.shift_reg[SPLD_STAGES-2:0]), $past(s_a)}))
        else $error("clockwise shift wrong");

    a_shift_down: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_rise && !s_dir) |=> (st_reg.shift_reg ==
            {$past(s_b), $past(st_reg.shift_reg[SPLD_STAGES-1:1])}))
        else $error("counter-clockwise shift wrong");

    a_cascade_cw: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir |=> (end_b_serial_io_out == $past(st_reg.shift_reg[SPLD_STAGES-1]))
            && !end_b_serial_io_oe_n && end_a_serial_io_oe_n)
        else $error("cascade not on end b");

    // an attempt started on the release edge still sees reset-time registers
    a_cascade_ccw: assert property (@(posedge pclk) disable iff (!presetn)
        (presetn && !s_dir) |=> (end_a_serial_io_out == $past(st_reg.shift_reg[0]))
            && !end_a_serial_io_oe_n && end_b_serial_io_oe_n)
        else $error("cascade not on end a");

    a_shift_indep: assert property (@(posedge pclk) disable iff (!presetn)
        (!clk_rise && $changed(s_latch_en)) |=> $stable(st_reg.shift_reg))
        else $error("latch enable disturbed shifting");

    a_latch_pass: assert property (@(posedge pclk) disable iff (!presetn)
        s_latch_en |=> (st_reg.latch_reg == $past(st_reg.shift_reg)))
        else $error("transparent latch did not follow");

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !s_latch_en |=> $stable(st_reg.latch_reg))
        else $error("closed latch changed");

    a_blank_high: assert property (@(posedge pclk) disable iff (!presetn)
        (presetn && !s_blank && !s_polar) |=> (&high_voltage_parallel_output))
        else $error("blank with low polarity not all high");

    a_blank_low: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_blank && s_polar) |=> (high_voltage_parallel_output == '0))
        else $error("blank with high polarity not all low");

    a_out_invert: assert property (@(posedge pclk) disable iff (!presetn)
        (s_blank && !s_polar) |=> (high_voltage_parallel_output[0] ==
            !$past(st_reg.latch_reg[0])))
        else $error("output one not inverted stage one");

    a_out_normal: assert property (@(posedge pclk) disable iff (!presetn)
        (s_blank && s_polar) |=> (high_voltage_parallel_output ==
            $past(st_reg.latch_reg)))
        else $error("outputs do not follow latches");

    a_out_inv_all: assert property (@(posedge pclk) disable iff (!presetn)
        (s_blank && !s_polar) |=> (high_voltage_parallel_output ==
            ~$past(st_reg.latch_reg)))
        else $error("outputs are not the inverted latches");

    a_ovr_set: assert property (@(posedge pclk) disable iff (!presetn)
        (latch_fall && st_reg.cap_en_reg && st_reg.pend_valid_reg && !fifo_in_ready)
            |=> st_reg.ovr_reg)
        else $error("lost frame did not raise overrun");

    a_cap_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && sel[0]) |=> (st_reg.cap_en_reg == $past(pwdata[SPLD_CTRL_CAP])))
        else $error("capture enable write lost");

    a_ends_excl: assert property (@(posedge pclk) disable iff (!presetn)
        end_a_serial_io_oe_n || end_b_serial_io_oe_n)
        else $error("both serial ends driven");

endmodule // spld_driver

// >>> verif/spld_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// display controller model
// ----------------------------------------------------------------
module spld_ctrl_model (
    input wire logic pclk,
    output logic sclk,
    output logic lat_en,
    output logic blank,
    output logic polar,
    output logic dir,
    output logic a_drv,
    output logic b_drv
);
    logic data;
    logic junk;

    initial begin
        {sclk, lat_en, data, junk} = 4'h0;
        {blank, polar, dir} = 3'h7;
    end

    // a released end toggles so that a stale level never looks valid
    always @(posedge pclk) begin
        junk <= ~junk;
    end
    assign a_drv = dir ? data : junk;
    assign b_drv = dir ? junk : data;

    // shift clock stands low between frames; high for 4 pclk, low for at least 5 pclk per bit
    task automatic shift_bit(input logic b);
        @(posedge pclk);
        data <= b;
        repeat (4) @(posedge pclk);
        sclk <= 1'b1;
        repeat (4) @(posedge pclk);
        sclk <= 1'b0;
    endtask

    // wig toggles blanking and polarity on every bit
    task automatic shift_frame(input logic [63:0] f, input logic wig);
        for (int i = 0; i < 64; i++) begin
            shift_bit(dir ? f[63-i] : f[i]);
            if (wig) begin
                blank <= ~blank;
                polar <= ~polar;
            end
        end
    endtask

    // latch enable rises 30 ns or more after the last clock rise
    task automatic pulse_latch;
        repeat (6) @(posedge pclk);
        lat_en <= 1'b1;
        repeat (8) @(posedge pclk);
        lat_en <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask

    task automatic set_mode(input logic b, input logic p, input logic d);
        @(posedge pclk);
        blank <= b;
        polar <= p;
        dir <= d;
        repeat (8) @(posedge pclk);
    endtask
endmodule // spld_ctrl_model

// >>> verif/tb_spld_driver.sv
`timescale 1ns/1ps
module tb_spld_driver
    import spld_pkg::*;
;
    localparam logic [63:0] F1 = 64'hA5C3_0F96_1E2D_7B48;
    localparam logic [63:0] F2 = 64'h3C69_D2B4_87E1_5AF0;
    localparam logic [63:0] G = 64'h9E37_79B9_4C15_2D61;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [SPLD_AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk, lat_en, blank, polar, dir, a_drv, b_drv;
    logic a_out, a_oe_n, b_out, b_oe_n;
    logic [SPLD_STAGES-1:0] hv;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic err;
    int drained;
    int errors = 0;
    int compares = 0;
    // wire level of each two-way end from both parties
    wire a_wire = a_oe_n ? a_drv : a_out;
    wire b_wire = b_oe_n ? b_drv : b_out;

    always #2.5 pclk = ~pclk;

    spld_driver dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_clock_in(sclk),
        .latch_transparent_enable(lat_en), .output_blanking_control(blank),
        .output_polarity_select(polar), .shift_direction(dir),
        .end_a_serial_io_in(a_wire), .end_a_serial_io_out(a_out),
        .end_a_serial_io_oe_n(a_oe_n), .end_b_serial_io_in(b_wire),
        .end_b_serial_io_out(b_out), .end_b_serial_io_oe_n(b_oe_n),
        .high_voltage_parallel_output(hv)
    );

    spld_ctrl_model ctrl_u (
        .pclk(pclk), .sclk(sclk), .lat_en(lat_en), .blank(blank), .polar(polar), .dir(dir),
        .a_drv(a_drv), .b_drv(b_drv)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        check({a_oe_n, b_oe_n}, 2'b11);
        presetn <= 1'b1;
        apb(1'b0, SPLD_CTRL_OFS, 32'h0);
        check(rd[0], SPLD_CAP_RST);
        apb(1'b1, SPLD_CTRL_OFS, 32'h0);
        apb(1'b0, SPLD_CTRL_OFS, 32'h0);
        check(rd[0], 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        ctrl_u.shift_frame(F1, 1'b0);
        ctrl_u.pulse_latch();
        check(hv, F1);
        check({b_oe_n, a_oe_n, b_wire}, {2'b01, F1[63]});
        ctrl_u.shift_frame(F2, 1'b1);
        repeat (10) @(posedge pclk);
        check(hv, F1);
        ctrl_u.pulse_latch();
        check(hv, F2);
        for (int i = 0; i < 4; i++) begin
            ctrl_u.set_mode(i[1], i[0], 1'b1);
            check(hv, !i[1] ? {64{~i[0]}} : (i[0] ? F2 : ~F2));
        end
        ctrl_u.shift_bit(1'b1);
        ctrl_u.pulse_latch();
        check(hv, {F2[62:0], 1'b1});
        ctrl_u.set_mode(1'b1, 1'b1, 1'b0);
        ctrl_u.shift_frame(G, 1'b0);
        ctrl_u.pulse_latch();
        check(hv, G);
        check({b_oe_n, a_oe_n, a_wire}, {2'b10, G[0]});
        apb(1'b0, SPLD_STATUS_OFS, 32'h0);
        check(rd[1:0], {G[0], 1'b0});
        // fill the snapshot buffer past full, then drain it
        apb(1'b1, SPLD_CTRL_OFS, 32'h1);
        repeat (10) ctrl_u.pulse_latch();
        apb(1'b0, SPLD_STATUS_OFS, 32'h0);
        check({rd[11:8], rd[4:2]}, 7'h45);
        drained = 0;
        for (int k = 0; k < 12; k++) begin
            apb(1'b0, SPLD_STATUS_OFS, 32'h0);
            if (rd[SPLD_ST_EMPTY] === 1'b1) break;
            apb(1'b0, SPLD_SNAP_LO_OFS, 32'h0);
            rd2 = rd;
            apb(1'b0, SPLD_SNAP_HI_OFS, 32'h0);
            check({rd, rd2}, G);
            drained++;
        end
        // eight buffered frames plus the one held pending
        check(drained, SPLD_FIFO_DEPTH + 1);
        apb(1'b0, SPLD_SNAP_LO_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, SPLD_STATUS_OFS, 32'h4);
        apb(1'b0, SPLD_STATUS_OFS, 32'h0);
        check(rd[SPLD_ST_OVR], 1'b0);
        final_report();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge pclk);
        errors++;
        final_report();
    end
endmodule // tb_spld_driver
